// *** hdl/csiaxf_baud.sv ***
/*
  Baud generator: gives a one-cycle tick at each serial clock half period.
  Assumes the divisor select is stable while a byte is moving.
*/
`timescale 1ns/10ps
`default_nettype none
module csiaxf_baud
(
  // clock and control
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [1:0] sel,
  // tick out
  output logic            half_tick
);
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic [4:0] half;
  logic       tick_next;

  // division of 6/8/16/32 means half periods of 3/4/8/16 clocks
  always_comb
  begin
    unique case (sel)
      2'h0: half = 5'(csiaxf_pkg::DIV_6 >> 1);
      2'h1: half = 5'(csiaxf_pkg::DIV_8 >> 1);
      2'h2: half = 5'(csiaxf_pkg::DIV_16 >> 1);
      2'h3: half = 5'(csiaxf_pkg::DIV_32 >> 1);
    endcase
    tick_next = 1'b0;
    cnt_next = cnt_reg + 5'h01;
    if (!run)
      cnt_next = 5'h00;
    else if (cnt_reg >= half - 5'h01)
    begin
      cnt_next = 5'h00;
      tick_next = 1'b1;
    end
  end

  // registers only
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cnt_reg   <= 5'h00;
      half_tick <= 1'b0;
    end
    else if (ce)
    begin
      cnt_reg   <= cnt_next;
      half_tick <= tick_next;
    end
  end
endmodule
`default_nettype wire

// *** hdl/csiaxf_pkg.sv ***
/*
  Constants and carrier types for the clocked serial auto-transfer channel.
  Assumes a single 250 MHz clock domain and a plain register port.
*/
package csiaxf_pkg;
  // register offsets on the register port
  localparam logic [5:0] ADDR_SHIFT  = 6'h00;
  localparam logic [5:0] ADDR_COUNT  = 6'h01;
  localparam logic [5:0] ADDR_MODE   = 6'h02;
  localparam logic [5:0] ADDR_STATUS = 6'h03;
  localparam logic [5:0] ADDR_TRIG   = 6'h04;
  localparam logic [5:0] ADDR_DIV    = 6'h05;
  localparam logic [5:0] ADDR_ENDPTR = 6'h06;
  localparam logic [5:0] ADDR_INTVL  = 6'h07;
  localparam logic [5:0] ADDR_MODE_BIT = 6'h08; // single-bit write port
  localparam logic [5:0] ADDR_RAM    = 6'h20; // 0x20..0x3F, one byte each
  // mode control fields
  localparam int MODE_EN     = 7;
  localparam int MODE_AUTO   = 6;
  localparam int MODE_REPEAT = 5;
  localparam int MODE_MASTER = 4;
  localparam int MODE_TXE    = 3;
  localparam int MODE_RXE    = 2;
  localparam int MODE_LSB    = 1;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] RST_INTVL = 6'h00;
  localparam logic [4:0] RST_ENDPTR = 5'h1F;
  // divider choices, full serial clock periods in clocks
  localparam logic [5:0] DIV_6  = 6'h06;
  localparam logic [5:0] DIV_8  = 6'h08;
  localparam logic [5:0] DIV_16 = 6'h10;
  localparam logic [5:0] DIV_32 = 6'h20;
  localparam int BITS_PER_BYTE = 8;
  localparam int RAM_BYTES = 32;

  typedef struct packed {
    logic       en;
    logic       auto_mode;
    logic       repeat_mode;
    logic       master;
    logic       txe;
    logic       rxe;
    logic       lsb_first;
    logic       rsvd;
  } csiaxf_mode_t;

  typedef struct packed {
    logic       sclk;
    logic       sclk_oe;
    logic       sout;
  } csiaxf_pins_t;
endpackage

// *** hdl/csiaxf_top.sv ***
/*
  Clocked serial channel with automatic block transmit/receive.
  Assumes serial pins are synchronous to clock; the slave clock must be
  well below the system clock so each edge is seen.
*/
`timescale 1ns/10ps
`default_nettype none
module csiaxf_top
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       ce,
  // register port
  input  wire logic [5:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // serial pins
  input  wire logic       serial_clock_pin_i,
  output logic            serial_clock_pin_o,
  output logic            serial_clock_pin_oe,
  input  wire logic       serial_in_pin,
  output logic            serial_out_pin,
  // completion request
  output logic            transfer_done_irq
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum {ST_IDLE, ST_LOAD, ST_SHIFT, ST_STORE, ST_GAP} csiaxf_st_t;

  csiaxf_pkg::csiaxf_mode_t mode_reg, mode_next;
  csiaxf_st_t st_reg, st_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] count_reg, count_next;
  logic [4:0] endptr_reg, endptr_next;
  logic [5:0] intvl_reg, intvl_next;
  logic [1:0] div_reg, div_next;
  logic [2:0] bit_reg, bit_next;
  logic [5:0] gap_reg, gap_next;
  logic       phase_reg, phase_next;   // 0: clock low half, 1: high half
  logic       busy_reg, busy_next;
  logic       trig_reg, trig_next;     // start request for automatic block
  logic [7:0] rdata_next;
  logic       irq_next;
  logic       sclk_next, sout_next, sin_samp_reg, sclk_in_reg;
  logic       half_tick;
  logic [7:0] ram [0:csiaxf_pkg::RAM_BYTES-1];
  logic [7:0] ram_rd;
  logic       ram_we;
  logic [4:0] ram_wa;
  logic [7:0] ram_wd;
  logic       rise, fall, en, any_edge_rise, any_edge_fall;
  logic       baud_run;

  // enable low is the stopped mode; the auto bit picks plain or block
  assign en = mode_reg.en;
  // the divider also paces the byte gap, else a master gap never ends
  assign baud_run = mode_reg.master &&
                    (st_reg == ST_SHIFT || st_reg == ST_GAP);

  ////////////////////////////////////////////////////////////////////////////
  // baud divider runs only while a master shifts or waits out a gap
  csiaxf_baud u_baud
  (
    .clock     (clock),
    .rst       (rst || !en),
    .ce        (ce),
    .run       (baud_run),
    .sel       (div_reg),
    .half_tick (half_tick)
  );

  // slave edges come from the external clock, sampled once
  assign rise = mode_reg.master ? (half_tick && !phase_reg)
                                : (serial_clock_pin_i && !sclk_in_reg);
  assign fall = mode_reg.master ? (half_tick && phase_reg)
                                : (!serial_clock_pin_i && sclk_in_reg);
  assign any_edge_rise = rise && st_reg == ST_SHIFT;
  assign any_edge_fall = fall && st_reg == ST_SHIFT;
  assign ram_rd = ram[count_reg[4:0]];

  ////////////////////////////////////////////////////////////////////////////
  // register writes, transfer sequencing and shift datapath
  always_comb
  begin
    mode_next   = mode_reg;
    shift_next  = shift_reg;
    count_next  = count_reg;
    endptr_next = endptr_reg;
    intvl_next  = intvl_reg;
    div_next    = div_reg;
    st_next     = st_reg;
    bit_next    = bit_reg;
    gap_next    = gap_reg;
    phase_next  = phase_reg;
    busy_next   = busy_reg;
    trig_next   = trig_reg;
    irq_next    = 1'b0;
    ram_we      = 1'b0;
    ram_wa      = addr[4:0];
    ram_wd      = wdata;
    if (wr)
    begin
      unique case (addr)
        csiaxf_pkg::ADDR_MODE: mode_next = wdata & 8'hFE;
        csiaxf_pkg::ADDR_MODE_BIT:
          mode_next[wdata[2:0]] = wdata[7] & (wdata[2:0] != 3'h0);
        csiaxf_pkg::ADDR_SHIFT:
          if (en && !busy_reg && !mode_reg.auto_mode)
          begin
            shift_next = wdata;
            busy_next  = 1'b1;
            st_next    = ST_SHIFT;
            bit_next   = 3'h0;
            phase_next = 1'b0;
          end
        csiaxf_pkg::ADDR_COUNT:  count_next  = wdata;
        csiaxf_pkg::ADDR_ENDPTR: endptr_next = wdata[4:0];
        csiaxf_pkg::ADDR_INTVL:  intvl_next  = wdata[5:0];
        csiaxf_pkg::ADDR_DIV:    div_next    = wdata[1:0];
        csiaxf_pkg::ADDR_TRIG:
          if (en && wdata[0] && mode_reg.auto_mode && !busy_reg)
            trig_next = 1'b1;
        default:
          if (addr[5] && en)
            ram_we = 1'b1;
      endcase
    end
    // transfer sequencing takes precedence over register writes in the same cycle
    unique case (st_reg)
      ST_IDLE:
        if (trig_reg)
        begin
          trig_next  = 1'b0;
          count_next = 8'h00;
          busy_next  = 1'b1;
          st_next    = ST_LOAD;
        end
      ST_LOAD:
      begin
        shift_next = mode_reg.txe ? ram_rd : csiaxf_pkg::RST_BYTE;
        bit_next   = 3'h0;
        phase_next = 1'b0;
        st_next    = ST_SHIFT;
      end
      ST_SHIFT:
      begin
        if (any_edge_rise)
          phase_next = 1'b1;
        if (any_edge_fall)
          phase_next = 1'b0;
        if (any_edge_rise)
        begin
          shift_next = mode_reg.lsb_first ? {sin_samp_reg, shift_reg[7:1]}
                                          : {shift_reg[6:0], sin_samp_reg};
          if (bit_reg == 3'h7)
            st_next = mode_reg.auto_mode ? ST_STORE : ST_IDLE;
          else
            bit_next = bit_reg + 3'h1;
          if (bit_reg == 3'h7 && !mode_reg.auto_mode)
          begin
            busy_next = 1'b0;
            irq_next  = 1'b1;
          end
        end
      end
      ST_STORE:
      begin
        ram_we = mode_reg.rxe;
        ram_wa = count_reg[4:0];
        ram_wd = shift_reg;
        gap_next = intvl_reg;
        if (count_reg[4:0] == endptr_reg)
        begin
          count_next = 8'h00;
          if (mode_reg.repeat_mode)
            st_next = ST_GAP;
          else
          begin
            count_next = count_reg;
            st_next    = ST_IDLE;
            busy_next  = 1'b0;
          end
          irq_next = 1'b1;
        end
        else
        begin
          count_next = count_reg + 8'h01;
          st_next    = ST_GAP;
        end
      end
      default:                                // ST_GAP
        if (gap_reg == 6'h00)
          st_next = ST_LOAD;
        else if (half_tick || !mode_reg.master)
          gap_next = gap_reg - 6'h01;
    endcase
    // pin levels: a master clock idles high and is low in the first half
    sclk_next = !(mode_reg.master && st_reg == ST_SHIFT && !phase_next);
    // data moves only on the falling side, so the far end never sees it
    // change on the edge where it samples; the last bit is held one cycle
    // past the final rising edge, then the line goes low
    if (st_reg != ST_SHIFT)
      sout_next = st_next == ST_SHIFT &&
                  (mode_reg.lsb_first ? shift_next[0] : shift_next[7]);
    else if (any_edge_fall)
      sout_next = mode_reg.lsb_first ? shift_reg[0] : shift_reg[7];
    else
      sout_next = serial_out_pin;
    sout_next = sout_next && mode_reg.txe;    // low with transmit off
    rdata_next = 8'h00;
    unique case (addr)
      csiaxf_pkg::ADDR_SHIFT:  rdata_next = shift_reg;
      csiaxf_pkg::ADDR_COUNT:  rdata_next = count_reg;
      csiaxf_pkg::ADDR_MODE:   rdata_next = mode_reg;
      csiaxf_pkg::ADDR_STATUS: rdata_next = {7'h00, busy_reg};
      csiaxf_pkg::ADDR_DIV:    rdata_next = {6'h00, div_reg};
      csiaxf_pkg::ADDR_ENDPTR: rdata_next = {3'h0, endptr_reg};
      csiaxf_pkg::ADDR_INTVL:  rdata_next = {2'h0, intvl_reg};
      default:
        if (addr[5])
          rdata_next = ram[addr[4:0]];
    endcase
    if (!rd)
      rdata_next = 8'h00;
    // a disabled unit is held in reset apart from its mode byte, RAM, read port, bit_reg, gap_reg, phase_reg, sin_samp_reg and sclk_in_reg
    if (!en)
    begin
      shift_next  = csiaxf_pkg::RST_BYTE;
      count_next  = csiaxf_pkg::RST_BYTE;
      endptr_next = csiaxf_pkg::RST_ENDPTR;
      intvl_next  = csiaxf_pkg::RST_INTVL;
      div_next    = 2'h0;
      st_next     = ST_IDLE;
      busy_next   = 1'b0;
      trig_next   = 1'b0;
      irq_next    = 1'b0;
      sclk_next   = 1'b1;
      sout_next   = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer RAM: no reset, contents are software-owned
  always_ff @(posedge clock)
  begin
    if (ce && ram_we)
      ram[ram_wa] <= ram_wd;
  end

  // state registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mode_reg            <= '0;
      shift_reg           <= csiaxf_pkg::RST_BYTE;
      count_reg           <= csiaxf_pkg::RST_BYTE;
      endptr_reg          <= csiaxf_pkg::RST_ENDPTR;
      intvl_reg           <= csiaxf_pkg::RST_INTVL;
      div_reg             <= 2'h0;
      st_reg              <= ST_IDLE;
      bit_reg             <= 3'h0;
      gap_reg             <= 6'h00;
      phase_reg           <= 1'b0;
      busy_reg            <= 1'b0;
      trig_reg            <= 1'b0;
      rdata               <= 8'h00;
      transfer_done_irq   <= 1'b0;
      serial_clock_pin_o  <= 1'b1;
      serial_clock_pin_oe <= 1'b0;
      serial_out_pin      <= 1'b0;
      sin_samp_reg        <= 1'b0;
      sclk_in_reg         <= 1'b1;
    end
    else if (ce)
    begin
      mode_reg            <= mode_next;
      shift_reg           <= shift_next;
      count_reg           <= count_next;
      endptr_reg          <= endptr_next;
      intvl_reg           <= intvl_next;
      div_reg             <= div_next;
      st_reg              <= st_next;
      bit_reg             <= bit_next;
      gap_reg             <= gap_next;
      phase_reg           <= phase_next;
      busy_reg            <= busy_next;
      trig_reg            <= trig_next;
      rdata               <= rdata_next;
      transfer_done_irq   <= irq_next;
      serial_clock_pin_o  <= sclk_next;
      serial_clock_pin_oe <= mode_next.master && mode_next.en;
      serial_out_pin      <= sout_next;
      sin_samp_reg        <= serial_in_pin;
      sclk_in_reg         <= serial_clock_pin_i;
    end
  end
endmodule
`default_nettype wire

// *** tb/csiaxf_asserts.sv ***
/*
  port checker for the serial auto-transfer channel
  assumes it is bound onto every csiaxf_top, one clock domain
*/
`timescale 1ns/10ps
`default_nettype none
module csiaxf_asserts
(
  // clock and reset
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       ce,
  // register port
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // serial pins and request
  input wire logic       serial_clock_pin_i,
  input wire logic       serial_clock_pin_o,
  input wire logic       serial_clock_pin_oe,
  input wire logic       serial_in_pin,
  input wire logic       serial_out_pin,
  input wire logic       transfer_done_irq
);
  logic [7:0] mode_q;
  logic [4:0] end_q;
  logic [1:0] div_q;
  logic [5:0] per_q;
  logic [8:0] rise_q;
  logic [8:0] rises;
  logic [5:0] per_exp;
  logic       sck_q;
  logic       sck;
  logic       rise;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////
  // wire level seen by both ends; slave mode takes the outside clock
  assign sck = serial_clock_pin_oe ? serial_clock_pin_o : serial_clock_pin_i;
  assign rise = sck & ~sck_q;
  assign rises = rise_q + {8'h00, rise};
  assign per_exp = (div_q == 2'h0) ? csiaxf_pkg::DIV_6 :
                   (div_q == 2'h1) ? csiaxf_pkg::DIV_8 :
                   (div_q == 2'h2) ? csiaxf_pkg::DIV_16 : csiaxf_pkg::DIV_32;
  // unit registers shadowed; disable clears them like the unit does
  always_ff @(posedge clock)
  begin
    if (rst || !mode_q[7])
    begin
      div_q  <= 2'h0;
      end_q  <= csiaxf_pkg::RST_ENDPTR;
      rise_q <= 9'h000;
    end
    else if (ce)
    begin
      if (wr && addr == csiaxf_pkg::ADDR_DIV)
        div_q <= wdata[1:0];
      if (wr && addr == csiaxf_pkg::ADDR_ENDPTR)
        end_q <= wdata[4:0];
      rise_q <= transfer_done_irq ? 9'h000 : rises;
    end
  end
  // mode shadow and clock period counter (saturates, idle gaps are long)
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mode_q <= 8'h00;
      sck_q  <= 1'b1;
      per_q  <= 6'h00;
    end
    else if (ce)
    begin
      if (wr && addr == csiaxf_pkg::ADDR_MODE)
        mode_q <= wdata;
      if (wr && addr == csiaxf_pkg::ADDR_MODE_BIT && wdata[2:0] != 3'h0)
        mode_q[wdata[2:0]] <= wdata[7];
      sck_q <= sck;
      per_q <= rise ? 6'h01 : (per_q == 6'h3F) ? per_q : per_q + 6'h01;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // first rise of each byte is excluded: it follows an idle stretch
  chk_div_period: assert property (
    rise && serial_clock_pin_oe && rise_q[2:0] != 3'h0 |-> per_q == per_exp)
    else $error("serial clock period off");
  chk_byte_edges: assert property (
    transfer_done_irq && !mode_q[6] |-> rises == 9'h008)
    else $error("single byte edge count off");
  chk_block_edges: assert property (
    transfer_done_irq && mode_q[6] |-> rises == ({4'h0, end_q} + 9'h001) << 3)
    else $error("block edge count off");
  chk_idle_pins: assert property (
    !mode_q[7] && $stable(mode_q) |->
      !serial_out_pin && serial_clock_pin_o && !serial_clock_pin_oe)
    else $error("disabled pins wrong");
  chk_tx_off_low: assert property (
    mode_q[7] && !mode_q[3] && $stable(mode_q) |-> !serial_out_pin)
    else $error("output not low with transmit off");
  chk_master_oe: assert property (
    mode_q[7] && $stable(mode_q) |-> serial_clock_pin_oe == mode_q[4])
    else $error("clock drive does not follow master select");
  chk_rdata_slot: assert property (
    !$past(rd) |-> rdata == 8'h00)
    else $error("read data outside its slot");
  chk_irq_pulse: assert property (
    transfer_done_irq |=> !transfer_done_irq)
    else $error("done request longer than one cycle");
  chk_irq_clk_high: assert property (
    transfer_done_irq |-> sck)
    else $error("done request with clock low");
  cov_single: cover property (transfer_done_irq && !mode_q[6] && mode_q[4]);
  cov_slave: cover property (transfer_done_irq && !serial_clock_pin_oe);
  cov_repeat: cover property (transfer_done_irq && mode_q[5]);
endmodule
bind csiaxf_top csiaxf_asserts u_chk
(
  .clock, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata,
  .serial_clock_pin_i, .serial_clock_pin_o, .serial_clock_pin_oe,
  .serial_in_pin, .serial_out_pin, .transfer_done_irq
);
`default_nettype wire

// *** tb/csiaxf_peer.sv ***
/*
  far-side serial peripheral: shifts MSB first, replies C3 xor byte count
  assumes the wire clock idles high and is slow against clock
*/
`timescale 1ns/10ps
`default_nettype none
module csiaxf_peer
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // serial side
  input  wire logic       sck,
  input  wire logic       dev_out,
  input  wire logic       slave_go,
  output logic            peer_sck,
  output logic            peer_out,
  // observation
  output logic      [7:0] rx_byte,
  output logic      [5:0] n_rx
);
  logic       sck_q;
  logic [2:0] bit_q;
  logic [1:0] rel_q;
  logic [7:0] sh_in;
  logic [7:0] sh_out;
  logic [7:0] gen_q;
  // own clock only while a slave byte is wanted, else stands high
  assign peer_sck = (gen_q == 8'h00) | gen_q[3];
  // drive on falling edge, sample on rising edge
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      {sck_q, bit_q, rel_q, sh_in, gen_q} <= {1'b1, 21'h0};
      {peer_out, rx_byte, n_rx, sh_out} <= {15'h0, 8'hC3};
    end
    else
    begin
      sck_q <= sck;
      rel_q <= {rel_q[0], 1'b0};
      gen_q <= slave_go ? 8'h78 : (gen_q == 8'h00) ? gen_q : gen_q - 8'h01;
      if (!sck && sck_q)
        {peer_out, sh_out} <= {sh_out, 1'b0};
      if (sck && !sck_q)
      begin
        sh_in <= {sh_in[6:0], dev_out};
        bit_q <= bit_q + 3'h1;
        if (bit_q == 3'h7)
        begin
          rx_byte <= {sh_in[6:0], dev_out};
          n_rx <= n_rx + 6'h01;
          sh_out <= 8'hC3 ^ {2'b00, n_rx + 6'h01};
          rel_q <= 2'b01;
        end
      end
      // a released line shows the inverse, never the last bit
      if (rel_q[1])
        peer_out <= ~peer_out;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
/*
  testbench for the serial channel: register tasks and a serial peer
  assumes the checker is bound onto the design
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic       clock = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [5:0] addr = 6'h00, k;
  logic [7:0] wdata = 8'h00, rdata, got, d, e, rx_byte;
  logic       pin_o, oe, sout, irq, peer_sck, peer_out, slave_go = 1'b0;
  logic [5:0] n_rx;
  wire  logic sck;
  int         failures = 0, n_tests = 0;
  always #2 clock = ~clock;
  assign sck = oe ? pin_o : peer_sck;
  csiaxf_top dut
  (
    .clock(clock), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .serial_clock_pin_i(sck),
    .serial_clock_pin_o(pin_o), .serial_clock_pin_oe(oe),
    .serial_in_pin(peer_out), .serial_out_pin(sout),
    .transfer_done_irq(irq)
  );
  csiaxf_peer u_peer
  (
    .clock(clock), .rst(rst), .sck(sck), .dev_out(sout),
    .slave_go(slave_go), .peer_sck(peer_sck), .peer_out(peer_out),
    .rx_byte(rx_byte), .n_rx(n_rx)
  );
  //////////////////////////////////////////////////////////////////////////
  // comparison, bus cycles and verdict
  task automatic chk(input string what, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] v);
    @(posedge clock);
    {addr, wdata, wr} <= {a, v, 1'b1};
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [5:0] a, output logic [7:0] v);
    @(posedge clock);
    {addr, rd} <= {a, 1'b1};
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    v = rdata;
  endtask
  // bounded wait; a 32-division byte is far shorter than the limit
  task automatic wait_irq();
    int i;
    i = 0;
    @(posedge clock);
    while (irq !== 1'b1 && i < 3000)
    begin
      @(posedge clock);
      i++;
    end
    chk("done request", {7'h00, irq}, 8'h01);
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int b = 0; b < 8; b++)
      rev[b] = v[7 - b];
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clock);
    failures++;
    give_verdict();
  end
  // main sequence
  initial
  begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd_reg(csiaxf_pkg::ADDR_SHIFT, got);
    chk("shift reset", got, 8'h00);
    rd_reg(csiaxf_pkg::ADDR_COUNT, got);
    chk("count reset", got, 8'h00);
    rd_reg(csiaxf_pkg::ADDR_MODE, got);
    chk("mode reset", got, 8'h00);
    rd_reg(6'h1F, got);
    chk("unmapped", got, 8'h00);
    // every divisor, transmit off through a bit write, then LSB first
    for (int i = 0; i < 6; i++)
    begin
      d = 8'h5A ^ 8'(i);
      if (i == 4)
        wr_reg(csiaxf_pkg::ADDR_MODE_BIT, 8'h03);
      else
        wr_reg(csiaxf_pkg::ADDR_MODE, (i == 5) ? 8'h9E : 8'h9C);
      rd_reg(csiaxf_pkg::ADDR_MODE, got);
      chk("mode", got, (i == 4) ? 8'h94 : (i == 5) ? 8'h9E : 8'h9C);
      wr_reg(csiaxf_pkg::ADDR_DIV, 8'(i % 4));
      k = n_rx;
      wr_reg(csiaxf_pkg::ADDR_SHIFT, d);
      if (i == 1)
      begin
        // hold the unit still mid-byte; the byte must still come out whole
        repeat (5) @(posedge clock);
        ce <= 1'b0;
        repeat (6) @(posedge clock);
        ce <= 1'b1;
      end
      wait_irq();
      rd_reg(csiaxf_pkg::ADDR_SHIFT, got);
      e = (i == 4) ? 8'h00 : (i == 5) ? rev(d) : d;
      chk("peer rx", rx_byte, e);
      e = 8'hC3 ^ {2'b00, k};
      chk("shift rx", got, (i == 5) ? rev(e) : e);
    end
    // slave byte clocked by the peer
    wr_reg(csiaxf_pkg::ADDR_MODE, 8'h8C);
    k = n_rx;
    wr_reg(csiaxf_pkg::ADDR_SHIFT, 8'h3C);
    @(posedge clock);
    slave_go <= 1'b1;
    @(posedge clock);
    slave_go <= 1'b0;
    wait_irq();
    rd_reg(csiaxf_pkg::ADDR_SHIFT, got);
    chk("slave peer rx", rx_byte, 8'h3C);
    chk("slave rx", got, 8'hC3 ^ {2'b00, k});
    // single-pass block of four bytes with a gap
    wr_reg(csiaxf_pkg::ADDR_MODE, 8'hDC);
    for (int j = 0; j < 4; j++)
      wr_reg(csiaxf_pkg::ADDR_RAM + 6'(j), 8'h10 + 8'(j));
    wr_reg(csiaxf_pkg::ADDR_ENDPTR, 8'h03);
    wr_reg(csiaxf_pkg::ADDR_INTVL, 8'h02);
    k = n_rx;
    wr_reg(csiaxf_pkg::ADDR_TRIG, 8'h01);
    rd_reg(csiaxf_pkg::ADDR_STATUS, got);
    chk("busy in block", got, 8'h01);
    wait_irq();
    chk("block bytes", {2'b00, n_rx - k}, 8'h04);
    chk("last sent", rx_byte, 8'h13);
    rd_reg(csiaxf_pkg::ADDR_COUNT, got);
    chk("stop count", got, 8'h03);
    rd_reg(csiaxf_pkg::ADDR_STATUS, got);
    chk("idle after block", got, 8'h00);
    for (int j = 0; j < 4; j++)
    begin
      rd_reg(csiaxf_pkg::ADDR_RAM + 6'(j), got);
      chk("ram rx", got, 8'hC3 ^ {2'b00, k + 6'(j)});
    end
    // repeating two-byte block, second pass sends first pass replies
    wr_reg(csiaxf_pkg::ADDR_MODE, 8'hFC);
    wr_reg(csiaxf_pkg::ADDR_ENDPTR, 8'h01);
    k = n_rx;
    wr_reg(csiaxf_pkg::ADDR_TRIG, 8'h01);
    wait_irq();
    wait_irq();
    chk("repeat bytes", {2'b00, n_rx - k}, 8'h04);
    chk("repeat data", rx_byte, 8'hC3 ^ {2'b00, k + 6'h01});
    // disable in mid-block: pins park and the unit clears
    wr_reg(csiaxf_pkg::ADDR_MODE, 8'h00);
    repeat (4) @(posedge clock);
    chk("parked pins", {6'h00, sout, pin_o}, 8'h01);
    rd_reg(csiaxf_pkg::ADDR_COUNT, got);
    chk("count cleared", got, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
